/* File: verilog/sram_ctl_pkg.sv */
// Notes on behaviour
// - Write is active when global write is low, or byte enable plus any lane low.
// - With global, byte enable and every lane high, the cycle is a read.
// - Byte writes touch exactly the lanes held low; none low or enable high reads.
// - Data pins drive or float from the current cycle and the output enable.
// - Output enable reaches the data drivers combinationally, never sampled on a clock.
// - Processor strobe with chip selected starts a read unless sleep is requested, write inputs ignored.
// - Writes happen only with controller strobe, or on later edges of a cycle started by either strobe.
// - Output enable is masked during write cycles so data pins never drive.
// - In a read, pins float if enable high or deselected, all drive if low.
// - Controller strobe alone, chip selected, write inputs active: single-cycle write.
// - Processor-started write takes two cycles, using write inputs of second edge.
// - Two-bit wrapping burst counter from address bits 1:0, linear or interleaved.
// - Advance low without any strobe steps the burst address for reads and writes.
package sram_ctl_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int COUNT_W = $clog2(FIFO_DEPTH) + 1;
  localparam int AXI_ADDR_W = 8;

  localparam logic [AXI_ADDR_W-1:0] REG_READ_DATA = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_WLOG_INFO = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] REG_WLOG_DATA = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_BURST_LSB = 2;
  localparam int ST_COUNT_LSB = 4;
  localparam int ST_OVF_BIT = 9;
  localparam int ST_SLEEP_BIT = 10;
  localparam int INFO_LANES_LSB = 16;
  localparam int INFO_VALID_BIT = 31;
  localparam int CTRL_CAPTURE_BIT = 0;

  localparam logic CTRL_CAPTURE_RESET = 1'h1;
  localparam logic [DATA_W-1:0] READ_DATA_RESET = 32'h0000_0000;
  localparam logic [LANES-1:0] ALL_LANES = 4'hF;
  localparam logic [LANES-1:0] NO_LANES = 4'h0;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  typedef enum logic [1:0] {
    CYC_DESEL = 2'b00,
    CYC_READ = 2'b01,
    CYC_WRITE = 2'b10
  } cycle_t;

  typedef struct packed {
    logic processor_addr_strobe_n_n;
    logic controller_addr_strobe_n_n;
    logic adv_n;
    logic gw_n;
    logic bwe_n;
    logic [LANES-1:0] bw_n;
    logic ce1_n;
    logic ce2;
    logic ce3_n;
    logic zz;
    logic interleave;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } pin_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] data;
  } wlog_t;

  localparam int WLOG_W = $bits(wlog_t);

endpackage

/* File: verilog/sram_wlog_fifo.sv */
`timescale 1ns/1ps
module sram_wlog_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  // Depth must be a power of two so the pointers wrap for free
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = DEPTH[PW:0];

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;

  assign count = st_reg.wptr - st_reg.rptr;
  assign in_ready = (count != DEPTH_CNT);
  assign out_valid = (count != '0);
  assign out_data = st_reg.mem[st_reg.rptr[PW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid && in_ready) begin
      st_next.mem[st_reg.wptr[PW-1:0]] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* File: verilog/sram_cycle_ctl.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sram_cycle_ctl (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_ENABLE_N,
  input wire logic [sram_ctl_pkg::LANES-1:0] BYTE_LANE_WRITE_N,
  input wire logic CHIP_SELECT_PRIMARY_N,
  input wire logic DEPTH_SELECT_HIGH,
  input wire logic DEPTH_SELECT_LOW_N,
  input wire logic SLEEP_REQUEST,
  input wire logic BURST_INTERLEAVE,
  input wire logic OUTPUT_DRIVE_ENABLE_N,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] DATA_IO_IN,
  output logic [sram_ctl_pkg::DATA_W-1:0] DATA_IO_OUT,
  output logic DATA_IO_OE_N,
  output logic WRITE_READY,
  input wire logic [sram_ctl_pkg::AXI_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [sram_ctl_pkg::AXI_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  typedef struct packed {
    sram_ctl_pkg::pin_t s1;
    sram_ctl_pkg::pin_t s2;
    sram_ctl_pkg::cycle_t state;
    logic [sram_ctl_pkg::ADDR_W-1:0] base;
    logic [sram_ctl_pkg::BURST_W-1:0] cnt;
    logic [sram_ctl_pkg::DATA_W-1:0] read_data;
    logic capture_en;
    logic overflow;
    logic aw_have;
    logic [sram_ctl_pkg::AXI_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  function automatic logic write_cond(input sram_ctl_pkg::pin_t p);
    write_cond = !p.gw_n || (!p.bwe_n && (p.bw_n != sram_ctl_pkg::ALL_LANES));
  endfunction

  function automatic logic [sram_ctl_pkg::LANES-1:0] write_lanes(input sram_ctl_pkg::pin_t p);
    if (!p.gw_n) begin
      write_lanes = sram_ctl_pkg::ALL_LANES;
    end else if (!p.bwe_n) begin
      write_lanes = ~p.bw_n;
    end else begin
      write_lanes = sram_ctl_pkg::NO_LANES;
    end
  endfunction

  function automatic logic [sram_ctl_pkg::BURST_W-1:0] burst_addr(
    input logic [sram_ctl_pkg::BURST_W-1:0] start,
    input logic [sram_ctl_pkg::BURST_W-1:0] cnt,
    input logic interleave
  );
    burst_addr = interleave ? (start ^ cnt) : (start + cnt);
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge_bytes = res;
  endfunction

  sram_ctl_pkg::pin_t pins_raw;
  sram_ctl_pkg::pin_t p;
  logic sel;
  logic start_p;
  logic start_c;
  logic wr;
  logic push;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  sram_ctl_pkg::wlog_t push_entry;
  sram_ctl_pkg::wlog_t head;
  logic [sram_ctl_pkg::WLOG_W-1:0] head_bits;
  logic [sram_ctl_pkg::COUNT_W-1:0] fifo_count;
  logic [31:0] status_word;
  logic [31:0] info_word;
  logic do_write;
  logic ar_take;

  assign pins_raw = '{processor_addr_strobe_n_n: PROCESSOR_ADDR_STROBE_N, controller_addr_strobe_n_n: CONTROLLER_ADDR_STROBE_N,
                      adv_n: BURST_ADVANCE_N, gw_n: GLOBAL_WRITE_N, bwe_n: BYTE_WRITE_ENABLE_N,
                      bw_n: BYTE_LANE_WRITE_N, ce1_n: CHIP_SELECT_PRIMARY_N, ce2: DEPTH_SELECT_HIGH,
                      ce3_n: DEPTH_SELECT_LOW_N, zz: SLEEP_REQUEST, interleave: BURST_INTERLEAVE,
                      addr: ADDR_IN, dq: DATA_IO_IN};

  // Every pin decision except the output enable reads the second synchroniser stage only
  assign p = st_reg.s2;
  assign sel = !p.ce1_n && p.ce2 && !p.ce3_n;
  assign start_p = !p.processor_addr_strobe_n_n;
  assign start_c = p.processor_addr_strobe_n_n && !p.controller_addr_strobe_n_n;
  assign wr = write_cond(p);
  assign head = sram_ctl_pkg::wlog_t'(head_bits);

  // Output enable stays off the clock so the turnaround follows the pin at once
  assign DATA_IO_OE_N = !((st_reg.state == sram_ctl_pkg::CYC_READ) && !OUTPUT_DRIVE_ENABLE_N);
  assign DATA_IO_OUT = st_reg.read_data;

  assign AWREADY = !st_reg.aw_have;
  assign WREADY = !st_reg.w_have;
  assign BVALID = st_reg.bvalid;
  assign BRESP = st_reg.bresp;
  assign ARREADY = !st_reg.rvalid;
  assign RVALID = st_reg.rvalid;
  assign RRESP = st_reg.rresp;
  assign RDATA = st_reg.rdata;
  assign do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  assign ar_take = ARVALID && !st_reg.rvalid;
  assign pop = ar_take && (ARADDR == sram_ctl_pkg::REG_WLOG_DATA) && fifo_out_valid;

  always_comb begin
    status_word = '0;
    status_word[sram_ctl_pkg::ST_STATE_LSB +: 2] = st_reg.state;
    status_word[sram_ctl_pkg::ST_BURST_LSB +: sram_ctl_pkg::BURST_W] =
      burst_addr(st_reg.base[sram_ctl_pkg::BURST_W-1:0], st_reg.cnt, p.interleave);
    status_word[sram_ctl_pkg::ST_COUNT_LSB +: sram_ctl_pkg::COUNT_W] = fifo_count;
    status_word[sram_ctl_pkg::ST_OVF_BIT] = st_reg.overflow;
    status_word[sram_ctl_pkg::ST_SLEEP_BIT] = p.zz;
    info_word = '0;
    info_word[sram_ctl_pkg::ADDR_W-1:0] = head.addr;
    info_word[sram_ctl_pkg::INFO_LANES_LSB +: sram_ctl_pkg::LANES] = head.lanes;
    info_word[sram_ctl_pkg::INFO_VALID_BIT] = fifo_out_valid;
  end

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_raw;
    st_next.s2 = st_reg.s1;
    push = 1'b0;
    if (p.zz) begin
      st_next.state = sram_ctl_pkg::CYC_DESEL;
    end else if ((start_p || start_c) && !sel) begin
      st_next.state = sram_ctl_pkg::CYC_DESEL;
    end else if (start_p) begin
      // Write inputs and advance are ignored on this edge
      st_next.state = sram_ctl_pkg::CYC_READ;
      st_next.base = p.addr;
      st_next.cnt = sram_ctl_pkg::BURST_ZERO;
    end else if (start_c) begin
      st_next.base = p.addr;
      st_next.cnt = sram_ctl_pkg::BURST_ZERO;
      st_next.state = wr ? sram_ctl_pkg::CYC_WRITE : sram_ctl_pkg::CYC_READ;
      push = wr;
    end else if (st_reg.state != sram_ctl_pkg::CYC_DESEL) begin
      if (!p.adv_n) begin
        st_next.cnt = st_reg.cnt + sram_ctl_pkg::BURST_STEP;
      end
      // Advance high leaves the counter where it was: suspend
      st_next.state = wr ? sram_ctl_pkg::CYC_WRITE : sram_ctl_pkg::CYC_READ;
      push = wr;
    end
    push_entry.addr = {st_next.base[sram_ctl_pkg::ADDR_W-1:sram_ctl_pkg::BURST_W],
                       burst_addr(st_next.base[sram_ctl_pkg::BURST_W-1:0], st_next.cnt, p.interleave)};
    push_entry.lanes = write_lanes(p);
    push_entry.data = p.dq;
    if (push && st_reg.capture_en && !fifo_in_ready) begin
      st_next.overflow = 1'b1;
    end

    if (AWVALID && !st_reg.aw_have) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = AWADDR;
    end
    if (WVALID && !st_reg.w_have) begin
      st_next.w_have = 1'b1;
      st_next.wdata = WDATA;
      st_next.wstrb = WSTRB;
    end
    if (do_write) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = sram_ctl_pkg::RESP_OKAY;
      unique case (st_reg.awaddr)
        sram_ctl_pkg::REG_READ_DATA: begin
          st_next.read_data = merge_bytes(st_reg.read_data, st_reg.wdata, st_reg.wstrb);
        end
        sram_ctl_pkg::REG_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.capture_en = st_reg.wdata[sram_ctl_pkg::CTRL_CAPTURE_BIT];
          end
        end
        sram_ctl_pkg::REG_STATUS: begin
          // A new overflow in the same cycle outlives the clear
          if (st_reg.wstrb[1] && st_reg.wdata[sram_ctl_pkg::ST_OVF_BIT] &&
              !(push && st_reg.capture_en && !fifo_in_ready)) begin
            st_next.overflow = 1'b0;
          end
        end
        sram_ctl_pkg::REG_WLOG_INFO, sram_ctl_pkg::REG_WLOG_DATA: begin
        end
        default: begin
          st_next.bresp = sram_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && BREADY) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && RREADY) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = sram_ctl_pkg::RESP_OKAY;
      unique case (ARADDR)
        sram_ctl_pkg::REG_READ_DATA: st_next.rdata = st_reg.read_data;
        sram_ctl_pkg::REG_STATUS: st_next.rdata = status_word;
        sram_ctl_pkg::REG_CTRL: st_next.rdata = {31'h0000_0000, st_reg.capture_en};
        sram_ctl_pkg::REG_WLOG_INFO: st_next.rdata = info_word;
        sram_ctl_pkg::REG_WLOG_DATA: st_next.rdata = fifo_out_valid ? head.data : 32'h0000_0000;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = sram_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.state <= sram_ctl_pkg::CYC_DESEL;
      st_reg.read_data <= sram_ctl_pkg::READ_DATA_RESET;
      st_reg.capture_en <= sram_ctl_pkg::CTRL_CAPTURE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Writes cannot stall the memory bus; a full log raises the overflow flag instead
  assign WRITE_READY = fifo_in_ready;

  sram_wlog_fifo #(
    .WIDTH(sram_ctl_pkg::WLOG_W),
    .DEPTH(sram_ctl_pkg::FIFO_DEPTH)
  ) u_wlog (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .in_valid(push && st_reg.capture_en),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(head_bits),
    .count(fifo_count)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_write_mask;
    (st_reg.state == sram_ctl_pkg::CYC_WRITE) |-> DATA_IO_OE_N;
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("data pins driven in write");

  property p_read_drive;
    (st_reg.state == sram_ctl_pkg::CYC_READ) |-> (DATA_IO_OE_N == OUTPUT_DRIVE_ENABLE_N);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read drive not following enable");

  property p_desel_float;
    (st_reg.state == sram_ctl_pkg::CYC_DESEL) |-> DATA_IO_OE_N;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("deselected yet driving");

  property p_proc_read;
    (!p.zz && start_p && sel) |=> (st_reg.state == sram_ctl_pkg::CYC_READ) && (st_reg.cnt == '0);
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor strobe did not read");

  property p_ctrl_write;
    (!p.zz && start_c && sel && wr) |-> push ##1 (st_reg.state == sram_ctl_pkg::CYC_WRITE);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("controller write missing");

  property p_no_write_at_start;
    (start_p) |-> !push;
  endproperty
  a_no_write_at_start: assert property (p_no_write_at_start) else $error("write on processor start");

  property p_deselect;
    (!p.zz && (start_p || start_c) && !sel) |=> (st_reg.state == sram_ctl_pkg::CYC_DESEL) && DATA_IO_OE_N;
  endproperty
  a_deselect: assert property (p_deselect) else $error("no deselect on inactive select");

  property p_advance;
    (!p.zz && !start_p && !start_c && !p.adv_n && st_reg.state != sram_ctl_pkg::CYC_DESEL)
      |=> (st_reg.cnt == $past(st_reg.cnt) + sram_ctl_pkg::BURST_STEP);
  endproperty
  a_advance: assert property (p_advance) else $error("burst did not advance");

  property p_suspend;
    (!p.zz && p.processor_addr_strobe_n_n && p.controller_addr_strobe_n_n && p.adv_n) |=> $stable(st_reg.cnt) && $stable(st_reg.base);
  endproperty
  a_suspend: assert property (p_suspend) else $error("burst moved while suspended");

  property p_lanes;
    (push && p.gw_n) |-> (push_entry.lanes == ~p.bw_n) && !p.bwe_n;
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong byte lanes");

  property p_global;
    (push && !p.gw_n) |-> (push_entry.lanes == sram_ctl_pkg::ALL_LANES);
  endproperty
  a_global: assert property (p_global) else $error("global write missed lanes");

  property p_read_idle;
    (!p.zz && !start_p && !start_c && !wr && st_reg.state != sram_ctl_pkg::CYC_DESEL)
      |=> (st_reg.state == sram_ctl_pkg::CYC_READ);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("inactive write inputs not a read");

  property p_second_edge;
    (!p.zz && start_p && sel) ##1 (!start_p && !start_c && wr && !p.zz) |-> push;
  endproperty
  a_second_edge: assert property (p_second_edge) else $error("second edge write lost");

  property p_burst_seq;
    (st_reg.state != sram_ctl_pkg::CYC_DESEL && !p.interleave) |->
      (status_word[sram_ctl_pkg::ST_BURST_LSB +: sram_ctl_pkg::BURST_W] ==
       2'(st_reg.base[sram_ctl_pkg::BURST_W-1:0] + st_reg.cnt));
  endproperty
  a_burst_seq: assert property (p_burst_seq) else $error("linear burst address wrong");

endmodule

/* File: dv/sram_host_model.sv */
`timescale 1ns/1ps
module sram_host_model (
  input wire logic clk,
  input wire sram_ctl_pkg::pin_t req,
  input wire logic oe_req,
  output sram_ctl_pkg::pin_t pins,
  output logic oe_n
);
  logic wr;
  // The device decides three edges after the pins move, so the enable must stay high that long
  logic [2:0] wr_hist;
  logic [31:0] last_dq;
  // Outside writes the data lines are released; a stale value would hide a missing drive
  always_comb begin
    wr = !req.gw_n || (!req.bwe_n && req.bw_n != 4'hF);
    pins = req;
    pins.dq = wr ? req.dq : ~last_dq;
    oe_n = (wr && (wr_hist != 3'h7)) ? 1'h1 : oe_req;
  end
  always_ff @(posedge clk) begin
    wr_hist <= {wr_hist[1:0], wr};
    last_dq <= pins.dq;
  end
endmodule

/* File: dv/pipelined_sync_sram_cycle_control_tb.sv */
`timescale 1ns/1ps
module pipelined_sync_sram_cycle_control_tb;
  localparam logic [15:0] BASE = 16'hA5C1;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  sram_ctl_pkg::pin_t req = {5'h1F, 4'hF, 3'h6, 2'h0, 16'h0, 32'h0};
  sram_ctl_pkg::pin_t pins;
  logic oe_req = 1'h1, oe_n, doe_n, wr_rdy;
  logic [31:0] din, dout, rd, rdata, wdata = 32'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [2:0] sel = 3'h2;
  logic sleep = 1'h0, ilv = 1'h0;
  int n_mismatch = 0, num_checks = 0;

  always #5 clk = ~clk;
  assign din = doe_n ? pins.dq : dout;

  sram_host_model host (.clk(clk), .req(req), .oe_req(oe_req), .pins(pins), .oe_n(oe_n));

  sram_cycle_ctl dut (
    .CLK_SYS(clk), .RSTN(rst_n), .ADDR_IN(pins.addr),
    .PROCESSOR_ADDR_STROBE_N(pins.processor_addr_strobe_n_n), .CONTROLLER_ADDR_STROBE_N(pins.controller_addr_strobe_n_n),
    .BURST_ADVANCE_N(pins.adv_n), .GLOBAL_WRITE_N(pins.gw_n), .BYTE_WRITE_ENABLE_N(pins.bwe_n),
    .BYTE_LANE_WRITE_N(pins.bw_n), .CHIP_SELECT_PRIMARY_N(pins.ce1_n), .DEPTH_SELECT_HIGH(pins.ce2),
    .DEPTH_SELECT_LOW_N(pins.ce3_n), .SLEEP_REQUEST(pins.zz), .BURST_INTERLEAVE(pins.interleave),
    .OUTPUT_DRIVE_ENABLE_N(oe_n), .DATA_IO_IN(din), .DATA_IO_OUT(dout), .DATA_IO_OE_N(doe_n),
    .WRITE_READY(wr_rdy), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Ready is looked at once settled, so the value used is the one the next edge samples
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      #1;
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
    end while (!bh);
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      #1;
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'h0;
    end while (!rh);
    rready <= 1'h0;
  endtask

  task automatic st();
    axr(sram_ctl_pkg::REG_STATUS, rd, rs);
  endtask

  task automatic cyc(input logic [4:0] c, input logic [3:0] b, input logic [31:0] d, input logic o);
    @(posedge clk);
    req <= {c, b, sel, sleep, ilv, BASE, d};
    oe_req <= o;
  endtask

  task automatic idle(input int n, input logic o);
    repeat (n) cyc(5'h1F, 4'hF, 32'h0, o);
  endtask

  task automatic pop(input logic [1:0] a, input logic [3:0] l, input logic [31:0] d);
    axr(sram_ctl_pkg::REG_WLOG_INFO, rd, rs);
    chk("log info", {1'h1, 11'h0, l, BASE[15:2], a}, rd);
    axr(sram_ctl_pkg::REG_WLOG_DATA, rd, rs);
    chk("log data", d, rd);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    st();
    chk("status reset", 32'h0, rd);
    axr(sram_ctl_pkg::REG_CTRL, rd, rs);
    chk("ctrl reset", 32'h1, rd);
    axr(8'h20, rd, rs);
    chk("unmapped rresp", 32'(sram_ctl_pkg::RESP_SLVERR), 32'(rs));
    axw(8'h20, 32'hFFFF_FFFF, 4'hF, rs);
    chk("unmapped bresp", 32'(sram_ctl_pkg::RESP_SLVERR), 32'(rs));
    axw(sram_ctl_pkg::REG_READ_DATA, 32'h1234_5678, 4'h5, rs);
    axr(sram_ctl_pkg::REG_READ_DATA, rd, rs);
    chk("strobed write", 32'h0034_0078, rd);
    // Processor start with write inputs active, then one write edge
    cyc(5'h0D, 4'hF, 32'h1111_0000, 1'h1);
    cyc(5'h1D, 4'hF, 32'h2222_0000, 1'h1);
    idle(4, 1'h1);
    st();
    chk("state", 32'h1, 32'(rd[1:0]));
    chk("count", 32'h1, 32'(rd[8:4]));
    cyc(5'h1F, 4'hF, 32'h0, 1'h0);
    #1 chk("drive enable", 32'h0, 32'(doe_n));
    chk("drive data", 32'h0034_0078, dout);
    cyc(5'h1F, 4'hF, 32'h0, 1'h1);
    #1 chk("float", 32'h1, 32'(doe_n));
    pop(2'h1, 4'hF, 32'h2222_0000);
    // Every lane pattern, then global write, then enable high with lanes low
    for (int i = 0; i < 16; i++) cyc(i == 0 ? 5'h16 : 5'h1E, 4'(i), 32'hC000_0000 + 32'(i), 1'h1);
    cyc(5'h1D, 4'hF, 32'hE000_0000, 1'h1);
    cyc(5'h1F, 4'h0, 32'h0, 1'h1);
    idle(4, 1'h1);
    st();
    chk("full count", 32'h10, 32'(rd[8:4]));
    chk("no overflow", 32'h0, 32'(rd[9]));
    chk("refused", 32'h0, 32'(wr_rdy));
    for (int i = 0; i < 15; i++) pop(2'h1, ~4'(i), 32'hC000_0000 + 32'(i));
    pop(2'h1, 4'hF, 32'hE000_0000);
    axr(sram_ctl_pkg::REG_WLOG_DATA, rd, rs);
    chk("empty log", 32'h0, rd);
    chk("ready", 32'h1, 32'(wr_rdy));
    // Linear burst beyond the log depth, output enable held low after the third write
    for (int i = 0; i < 20; i++) begin
      cyc(i == 0 ? 5'h11 : 5'h19, 4'hF, 32'hB000_0000 + 32'(i), 1'h0);
      if (i > 4) #1 chk("masked drive", 32'h1, 32'(doe_n));
    end
    idle(4, 1'h1);
    st();
    chk("burst hold", 32'h0, 32'(rd[3:2]));
    chk("overflow", 32'h1, 32'(rd[9]));
    axw(sram_ctl_pkg::REG_STATUS, 32'h0000_0200, 4'h2, rs);
    st();
    chk("overflow clear", 32'h0, 32'(rd[9]));
    for (int i = 0; i < 16; i++) pop(2'(i + 1), 4'hF, 32'hB000_0000 + 32'(i));
    ilv <= 1'h1;
    for (int i = 0; i < 4; i++) cyc(i == 0 ? 5'h11 : 5'h19, 4'hF, 32'hD000_0000 + 32'(i), 1'h0);
    idle(4, 1'h1);
    for (int i = 0; i < 4; i++) pop(2'h1 ^ 2'(i), 4'hF, 32'hD000_0000 + 32'(i));
    // Each select inactive in turn, then sleep
    for (int k = 0; k < 4; k++) begin
      sel <= k == 0 ? 3'h6 : k == 1 ? 3'h0 : k == 2 ? 3'h3 : 3'h2;
      sleep <= k == 3;
      cyc(5'h17, 4'hF, 32'h0, 1'h0);
      idle(4, 1'h0);
      #1 chk("deselect float", 32'h1, 32'(doe_n));
      st();
      chk("deselect state", {21'h0, k == 3, 10'h0}, rd & 32'h0000_0403);
      sleep <= 1'h0;
      idle(2, 1'h0);
      sel <= 3'h2;
      cyc(5'h0F, 4'hF, 32'h0, 1'h0);
      idle(4, 1'h0);
      #1 chk("reselect drive", 32'h0, 32'(doe_n));
    end
    end_sim();
  end
endmodule
